// file: design/prc_pkg.sv
// package for the refresh and power control block of the pseudo-static memory
// assumes a 20 MHz core clock; all times below turn into cycle counts here
package prc_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_INIT_US = 150;
  localparam int T_EXIT_US = 10;
  localparam int T_MAX_LOW_US = 4;
  // least times round up to whole cycles
  localparam int INIT_CYC = (T_INIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXIT_CYC = (T_EXIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest time rounds down
  localparam int MAX_LOW_CYC = (T_MAX_LOW_US * 1000) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  // ****************************************
  // register layout
  // ****************************************
  localparam int ADDR_W = 22;
  localparam logic [15:0] REFRESH_CONFIG_RESET = 16'h0010;
  localparam int DEEP_SLEEP_BIT = 4;
  localparam int REGION_SEL_MSB = 2;
  localparam int REGION_SEL_LSB = 0;
  localparam logic [2:0] REGION_SEL_NONE = 3'h4;
  localparam logic [2:0] REGION_SEL_FULL = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_TOP = 22'h3fffff;
  // register select codes: pin path and software path
  localparam logic [1:0] SEL_PIN_REFRESH = 2'h0;
  localparam logic [1:0] SEL_PIN_IDENT = 2'h1;
  localparam logic [15:0] SEL_SW_REFRESH = 16'h0000;
  localparam logic [15:0] SEL_SW_IDENT = 16'h0002;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {PRC_REG_NONE, PRC_REG_REFRESH, PRC_REG_IDENT} prc_reg_t;
  typedef enum logic [1:0] {PRC_ACTIVE, PRC_SLEEP, PRC_WAKE, PRC_INIT} prc_state_t;
endpackage

// file: design/prc_refresh_ctrl.sv
// refresh and deep sleep control of the memory core
// assumes chip select comes from a pin; register strobes come from the
// device bus logic on the same clock
// Overview of operation
// - self-refresh walks only the region that the partial refresh field picks
// - field gives full, half, quarter, eighth or none; 000 full, 100 none
// - bit 2 clear anchors region at address zero, set anchors it at top
// - deep sleep bit enables or halts all refresh activity
// - array contents are lost in deep sleep; data after exit is corrupt
// - leaving deep sleep runs a 150 us initialization before normal access
// - deep sleep entered when bit written zero and then chip select high
// - chip select low at least 10 us ends deep sleep and sets the bit
// - all configuration bits except the deep sleep bit survive deep sleep
// - identity register reports maker, generation, configuration; read-only
// - identity selected by pin with address 01b or software code 0002h
// - refresh config selected by pin with address 00b or software code 0000h
// - refresh config loads 0010h at power-up
// - refresh config reads back all 16 bits as written
`timescale 1ns/1ps
`default_nettype none
module prc_refresh_ctrl
  import prc_pkg::*;
#(
  parameter logic [15:0] IDENT_VALUE = 16'h1234, // arbitrary value
  parameter logic [ADDR_W-1:0] REFRESH_STEP = 22'h000100
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // chip select pin, active low
  input wire logic select_n_in,
  // register access from the bus logic
  input wire logic config_reg_enable_in,
  input wire logic [1:0] addr_sel_in,
  input wire logic sw_seq_in,
  input wire logic [15:0] sw_code_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out,
  output logic rdata_valid_out,
  // refresh engine towards the core
  output logic refresh_strobe_out,
  output logic [ADDR_W-1:0] refresh_addr_out,
  // power status
  output logic deep_sleep_out,
  output logic init_busy_out,
  output logic array_lost_out,
  output logic [15:0] refresh_config_out
);
  // ****************************************
  // decode helpers
  // ****************************************
  // pin path and software path reach the same registers
  function automatic prc_reg_t reg_decode(input logic cfg_en, input logic [1:0] a,
                                          input logic sw, input logic [15:0] code);
    prc_reg_t r;
    r = PRC_REG_NONE;
    if (cfg_en) begin
      if (a == SEL_PIN_REFRESH) r = PRC_REG_REFRESH;
      else if (a == SEL_PIN_IDENT) r = PRC_REG_IDENT;
    end else if (sw) begin
      if (code == SEL_SW_REFRESH) r = PRC_REG_REFRESH;
      else if (code == SEL_SW_IDENT) r = PRC_REG_IDENT;
    end
    return r;
  endfunction

  // region size halves per step; bit 2 picks the anchor
  function automatic logic [ADDR_W-1:0] region_lo(input logic [2:0] rsel);
    logic [ADDR_W-1:0] size;
    size = (ADDR_TOP >> rsel[1:0]) + 22'h000001;
    if (rsel[2] && rsel != REGION_SEL_NONE) region_lo = ADDR_TOP - size + 22'h000001;
    else region_lo = '0;
  endfunction

  function automatic logic [ADDR_W-1:0] region_hi(input logic [2:0] rsel);
    if (rsel[2]) region_hi = ADDR_TOP;
    else region_hi = ADDR_TOP >> rsel[1:0];
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic sel_meta, sel_sync, sel_prev;
  logic [15:0] refresh_config, next_refresh_config;
  prc_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [ADDR_W-1:0] ptr, next_ptr;
  logic [ADDR_W-1:0] next_addr;
  logic next_strobe, next_lost, next_rvalid;
  logic [15:0] next_rdata;
  logic [2:0] region_sel;
  logic [ADDR_W-1:0] lo, hi, cur;
  logic sel_rise, opportunity;
  prc_reg_t sel;

  assign region_sel = refresh_config[REGION_SEL_MSB:REGION_SEL_LSB];
  assign lo = region_lo(region_sel);
  assign hi = region_hi(region_sel);
  assign sel = reg_decode(config_reg_enable_in, addr_sel_in, sw_seq_in, sw_code_in);
  assign sel_rise = sel_sync && !sel_prev;
  // select is high (sampled) so the core is free for one refresh
  assign opportunity = sel_sync;
  assign cur = (ptr >= lo && ptr <= hi) ? ptr : lo;

  // pin synchroniser; the second stage and its one-cycle delayed copy are looked at
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sel_meta <= 1'b1;
      sel_sync <= 1'b1;
      sel_prev <= 1'b1;
    end else begin
      sel_meta <= select_n_in;
      sel_sync <= sel_meta;
      sel_prev <= sel_sync;
    end
  end

  // next values for power state, register, refresh walk and reads
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_refresh_config = refresh_config;
    next_ptr = ptr;
    next_addr = refresh_addr_out;
    next_strobe = 1'b0;
    next_lost = array_lost_out;
    next_rvalid = 1'b0;
    next_rdata = rdata_out;
    unique case (state)
      PRC_ACTIVE: begin
        // writes only while awake; identity register ignores them
        if (reg_wr_in && sel == PRC_REG_REFRESH) begin
          next_refresh_config = wdata_in;
        end
        // bit cleared earlier, select now released
        if (!refresh_config[DEEP_SLEEP_BIT] && sel_rise) begin
          next_state = PRC_SLEEP;
          next_lost = 1'b1;
        end else if (opportunity && region_sel != REGION_SEL_NONE) begin
          // walk the region; out-of-region pointer restarts at the base
          next_strobe = 1'b1;
          next_addr = cur;
          if (cur > hi - REFRESH_STEP) next_ptr = lo;
          else next_ptr = cur + REFRESH_STEP;
        end
        if (reg_rd_in) begin
          next_rvalid = 1'b1;
          if (sel == PRC_REG_REFRESH) next_rdata = refresh_config;
          else if (sel == PRC_REG_IDENT) next_rdata = IDENT_VALUE;
          else next_rdata = 16'h0000;
        end
      end
      PRC_SLEEP: begin
        // no refresh at all; other config bits stay put
        next_cnt = '0;
        if (!sel_sync) next_state = PRC_WAKE;
      end
      PRC_WAKE: begin
        // select must stay low for the whole exit time
        if (sel_sync) begin
          next_state = PRC_SLEEP;
        end else if (cnt == CNT_W'(EXIT_CYC - 1)) begin
          next_state = PRC_INIT;
          next_cnt = '0;
          next_refresh_config[DEEP_SLEEP_BIT] = 1'b1;
        end else begin
          next_cnt = cnt + CNT_W'(1);
        end
      end
      PRC_INIT: begin
        // fixed initialization; accesses are not served meanwhile
        if (cnt == CNT_W'(INIT_CYC - 1)) begin
          next_state = PRC_ACTIVE;
          next_cnt = '0;
        end else begin
          next_cnt = cnt + CNT_W'(1);
        end
      end
    endcase
  end

  // register the next values
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= PRC_ACTIVE;
      cnt <= '0;
      refresh_config <= REFRESH_CONFIG_RESET;
      ptr <= '0;
      refresh_addr_out <= '0;
      refresh_strobe_out <= 1'b0;
      array_lost_out <= 1'b0;
      rdata_valid_out <= 1'b0;
      rdata_out <= 16'h0000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      refresh_config <= next_refresh_config;
      ptr <= next_ptr;
      refresh_addr_out <= next_addr;
      refresh_strobe_out <= next_strobe;
      array_lost_out <= next_lost;
      rdata_valid_out <= next_rvalid;
      rdata_out <= next_rdata;
    end
  end

  // sleep and init status is decoded straight from the state register
  assign deep_sleep_out = (state == PRC_SLEEP) || (state == PRC_WAKE);
  assign init_busy_out = (state == PRC_INIT);
  assign refresh_config_out = refresh_config;

  // ****************************************
  // check helpers
  // ****************************************
  // run of synced select-low cycles; saturates so a long hold cannot wrap
  // and fake a short one, and spares the exit check a 200-deep repetition
  logic [CNT_W-1:0] low_run, next_low_run;

  // next value of the low run
  always_comb begin
    next_low_run = low_run;
    if (sel_sync) begin
      next_low_run = '0;
    end else if (low_run != '1) begin
      next_low_run = low_run + CNT_W'(1);
    end
  end

  // register the low run
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      low_run <= '0;
    end else begin
      low_run <= next_low_run;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  chk_sleep_entry: assert property (
    state == PRC_ACTIVE && !refresh_config[DEEP_SLEEP_BIT] && sel_rise
    |=> state == PRC_SLEEP && array_lost_out)
    else $error("deep sleep not entered");
  chk_wake_time: assert property (
    $rose(init_busy_out) |-> low_run >= CNT_W'(EXIT_CYC))
    else $error("exit taken too early");
  chk_exit_sets_bit: assert property (
    $rose(init_busy_out) |-> refresh_config[DEEP_SLEEP_BIT] && $past(state) == PRC_WAKE)
    else $error("exit without setting deep sleep bit");
  chk_init_length: assert property (
    init_busy_out && cnt == CNT_W'(INIT_CYC - 1) |=> state == PRC_ACTIVE)
    else $error("init period wrong");
  chk_init_busy: assert property (
    init_busy_out |-> cnt < CNT_W'(INIT_CYC))
    else $error("init counter overran");
  chk_no_sleep_refresh: assert property (
    $past(state) != PRC_ACTIVE |-> !refresh_strobe_out)
    else $error("refresh while asleep");
  chk_refresh_region: assert property (
    refresh_strobe_out |-> refresh_addr_out >= $past(lo) && refresh_addr_out <= $past(hi))
    else $error("refresh outside region");
  chk_none_region: assert property (
    $past(region_sel) == REGION_SEL_NONE |-> !refresh_strobe_out)
    else $error("refresh with empty region");
  chk_sleep_retain: assert property (
    state != PRC_ACTIVE |=> refresh_config[15:5] == $past(refresh_config[15:5])
    && refresh_config[3:0] == $past(refresh_config[3:0]))
    else $error("config lost in deep sleep");
  chk_ident_ro: assert property (
    reg_wr_in && sel == PRC_REG_IDENT |=> $stable(refresh_config))
    else $error("identity write had effect");
  chk_readback: assert property (
    state == PRC_ACTIVE && reg_rd_in && sel == PRC_REG_REFRESH
    |=> rdata_valid_out && rdata_out == $past(refresh_config))
    else $error("readback mismatch");
  // wake is abandoned at once, and the lost flag only clears by reset
  chk_wake_abort: assert property (
    state == PRC_WAKE && sel_sync |=> state == PRC_SLEEP)
    else $error("wake not abandoned on select high");
  chk_lost_sticky: assert property (
    array_lost_out |=> array_lost_out)
    else $error("lost flag cleared");
  chk_refresh_gate: assert property (
    refresh_strobe_out |-> $past(sel_sync) && $past(state) == PRC_ACTIVE)
    else $error("refresh without opportunity");
  chk_write_lands: assert property (
    state == PRC_ACTIVE && reg_wr_in && sel == PRC_REG_REFRESH
    |=> refresh_config == $past(wdata_in))
    else $error("register write lost");

  cov_sleep: cover property (state == PRC_SLEEP ##1 state == PRC_WAKE);
  cov_init_done: cover property (init_busy_out ##1 state == PRC_ACTIVE);
  cov_top_region: cover property (refresh_strobe_out && region_sel == 3'h7);
  cov_ident_read: cover property (reg_rd_in && sel == PRC_REG_IDENT);
  cov_wake_abort: cover property (state == PRC_WAKE && sel_sync ##1 state == PRC_SLEEP);
endmodule
`default_nettype wire

// file: testbench/prc_host_model.sv
// host controller stand-in that drives the active-low chip select pin
// assumes the memory block's clock; select goes high one cycle in every 20
`timescale 1ns/1ps
`default_nettype none
module prc_host_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // bench command: hold select low to wake the memory
  input wire logic hold_low_in,
  // chip select pin
  output logic select_n_out
);
  logic [4:0] gap;
  // a clocked select-high well inside 80 cycles, unless a wake is commanded
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gap <= 5'h00;
      select_n_out <= 1'b1;
    end else begin
      gap <= (gap == 5'h13) ? 5'h00 : gap + 5'h01;
      select_n_out <= !hold_low_in && (gap == 5'h13);
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the refresh and deep sleep control block
// assumes the host model on chip select and a 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import prc_pkg::*;
  localparam logic [15:0] ID = 16'h2b6d; // arbitrary value
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic hold_low = 1'b0;
  logic select_n, cfg_en = 1'b0, sw_seq = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [1:0] addr_sel = 2'h0;
  logic [15:0] sw_code = 16'h0000, wdata = 16'h0000, rdata, cfg, q;
  logic rvalid, strobe, sleep, busy, lost, v;
  logic [ADDR_W-1:0] raddr;
  int mismatches = 0, comparisons = 0, cycles = 0;
  always #25 clk_in = ~clk_in;
  prc_host_model host_u (.clk_in(clk_in), .rstn_in(rstn_in), .hold_low_in(hold_low),
    .select_n_out(select_n));
  prc_refresh_ctrl #(.IDENT_VALUE(ID)) dut_u (.clk_in(clk_in), .rstn_in(rstn_in),
    .select_n_in(select_n), .config_reg_enable_in(cfg_en), .addr_sel_in(addr_sel),
    .sw_seq_in(sw_seq), .sw_code_in(sw_code), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .wdata_in(wdata), .rdata_out(rdata), .rdata_valid_out(rvalid),
    .refresh_strobe_out(strobe), .refresh_addr_out(raddr), .deep_sleep_out(sleep),
    .init_busy_out(busy), .array_lost_out(lost), .refresh_config_out(cfg));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic tally_and_finish();
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one register access; pin path uses sel[1:0], software path the whole code
  task automatic acc(input logic wr, input logic pin, input logic [15:0] sel,
                     input logic [15:0] d);
    @(posedge clk_in);
    cfg_en <= pin;
    sw_seq <= !pin;
    addr_sel <= sel[1:0];
    sw_code <= sel;
    reg_wr <= wr;
    reg_rd <= !wr;
    wdata <= d;
    @(posedge clk_in);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    q = rdata;
    v = rvalid;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_regs();
    acc(1'b0, 1'b1, 16'h0000, 16'h0000);
    check({v, q}, {1'b1, 16'h0010});
    acc(1'b1, 1'b1, 16'h0001, 16'h5555);
    acc(1'b0, 1'b1, 16'h0000, 16'h0000);
    check({v, q}, {1'b1, 16'h0010});
    acc(1'b0, 1'b0, 16'h0002, 16'h0000);
    check({v, q}, {1'b1, ID});
    acc(1'b0, 1'b1, 16'h0002, 16'h0000);
    check({v, q}, 17'h10000);
    acc(1'b1, 1'b0, 16'h0000, 16'h0017);
    acc(1'b0, 1'b1, 16'h0000, 16'h0000);
    check({v, q}, 17'h10017);
  endtask
  // every field code: strobes stay inside the selected region
  task automatic test_region();
    logic [ADDR_W-1:0] lo, hi;
    int hits;
    for (int c = 0; c < 8; c++) begin
      hi = c[2] ? 22'h3fffff : (22'h3fffff >> c[1:0]);
      lo = c[2] ? 22'h3fffff - (22'h3fffff >> c[1:0]) : 22'h000000;
      hits = 0;
      acc(1'b1, 1'b1, 16'h0000, 16'h0010 | {13'h0000, c[2:0]});
      repeat (3) @(posedge clk_in);
      repeat (200) begin
        @(posedge clk_in);
        #1;
        if (strobe !== 1'b0) begin
          hits++;
          check(raddr >= lo && raddr <= hi, 1'b1);
        end
      end
      check(hits > 0, c != 4);
    end
  endtask
  task automatic test_sleep();
    int n;
    acc(1'b1, 1'b1, 16'h0000, 16'h0003);
    n = 0;
    while (sleep !== 1'b1 && n < 60) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check({sleep, lost, cfg}, {2'b11, 16'h0003});
    n = 0;
    repeat (60) begin
      @(posedge clk_in);
      #1;
      if (strobe !== 1'b0) n++;
    end
    acc(1'b0, 1'b1, 16'h0000, 16'h0000);
    check({n[7:0], v}, 9'h000);
    // line up on the host's last select-high pulse, then hold select low
    while (select_n !== 1'b1) begin
      @(posedge clk_in);
      #1;
    end
    @(posedge clk_in);
    hold_low <= 1'b1;
    n = 1;
    while (busy !== 1'b1 && n < 400) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check(n >= EXIT_CYC && n <= EXIT_CYC + 10, 1'b1);
    check(cfg, 16'h0013);
    @(posedge clk_in);
    hold_low <= 1'b0;
    acc(1'b0, 1'b1, 16'h0000, 16'h0000);
    check(v, 1'b0);
    n = 4;
    while (busy === 1'b1 && n < 3100) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check(n, INIT_CYC + 1);
    acc(1'b0, 1'b1, 16'h0000, 16'h0000);
    check({lost, v, q}, {2'b11, 16'h0013});
  endtask
  // hang guard well beyond the expected run
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    test_regs();
    test_region();
    test_sleep();
    tally_and_finish();
  end
endmodule
`default_nettype wire
